// ### rtl/upr_regs.svh
// constants for the power, reset and strap pin logic and its board-side APB model
// assumes inclusion by bare name; definitions only
`ifndef UPR_REGS_SVH
`define UPR_REGS_SVH

`define UPR_CLK_PERIOD_NS 10
`define UPR_POR_WAIT_NS 5000000
`define UPR_LED_PULSE_NS 1000000
`define UPR_OSC_HALF_NS 83

`define UPR_PID_W 16
// product codes are arbitrary neutral values
`define UPR_PID_DEFAULT 16'h1a2b
`define UPR_PID_ALT 16'h1a2c

// synchroniser lanes and their idle levels
`define UPR_SYN_W 6
`define UPR_SYN_RSTN 0
`define UPR_SYN_PWRSEL 1
`define UPR_SYN_TEST 2
`define UPR_SYN_CS 3
`define UPR_SYN_SK 4
`define UPR_SYN_DATA 5
`define UPR_SYN_INIT 6'h39

// board-side APB map
`define UPR_ADDR_W 12
`define UPR_OFF_CTRL 12'h000
`define UPR_OFF_STATUS 12'h004
`define UPR_CTRL_W 5
`define UPR_CTRL_RESET 5'h00
`define UPR_CTRL_EXT_RST 0
`define UPR_CTRL_SELF_PWR 1
`define UPR_CTRL_TEST 2
`define UPR_CTRL_CS_PD 3
`define UPR_CTRL_SK_PD 4
`define UPR_STAT_W 11

`endif

// ### rtl/upr_pkg.sv
// types imported by both ends; the pin interface uses none of them
// assumes upr_regs.svh alongside
package upr_pkg;
  typedef enum logic [1:0] {
    UPR_RS_HIZ = 2'b00,
    UPR_RS_LOW = 2'b01,
    UPR_RS_HIGH = 2'b10
  } upr_rst_state_t;
endpackage : upr_pkg

// ### rtl/upr_if.sv
// pin-level carrier between the bridge device and the board
// resolves the three eeprom pins from their enables, the internal pull-ups and the board's pull-downs
`timescale 1ns/10ps
interface upr_if;
  // device-driven pins
  logic ee_cs_o, ee_cs_oe;
  logic ee_sk_o, ee_sk_oe;
  logic ee_data_o, ee_data_oe;
  logic rst_out_o, rst_out_oe;
  logic tx_led_o, tx_led_oe;
  logic rx_led_o, rx_led_oe;
  logic suspend_n;
  logic power_enable_n;
  logic osc_out;
  // board-driven pins and fitted pull-downs
  logic reset_in_n;
  logic power_source_select;
  logic test_mode;
  logic cs_pulldown;
  logic sk_pulldown;
  // resolved levels; undriven pins sit at the internal pull-up unless pulled down
  logic ee_cs_lvl, ee_sk_lvl, ee_data_lvl;
  assign ee_cs_lvl = ee_cs_oe ? ee_cs_o : ~cs_pulldown;
  assign ee_sk_lvl = ee_sk_oe ? ee_sk_o : ~sk_pulldown;
  assign ee_data_lvl = ee_data_oe ? ee_data_o : 1'b1;

  modport dev (
    output ee_cs_o, ee_cs_oe, ee_sk_o, ee_sk_oe, ee_data_o, ee_data_oe,
    output rst_out_o, rst_out_oe, tx_led_o, tx_led_oe, rx_led_o, rx_led_oe,
    output suspend_n, power_enable_n, osc_out,
    input reset_in_n, power_source_select, test_mode,
    input ee_cs_lvl, ee_sk_lvl, ee_data_lvl
  );
  modport brd (
    input ee_cs_oe, ee_sk_oe, ee_data_oe, rst_out_o, rst_out_oe,
    input tx_led_oe, rx_led_oe, suspend_n, power_enable_n, osc_out,
    output reset_in_n, power_source_select, test_mode, cs_pulldown, sk_pulldown
  );
endinterface : upr_if

// ### rtl/upr_device.sv
// bridge pin logic: reset generator, straps, power control, activity leds, osc out
// assumes the usb engine pulses its events on CLK_SYS; pins arrive asynchronously
// Behaviour
// - cs pulled low selects 48 MHz mode
// - eeprom pins float in reset, clock driven after
// - sk pulled low selects alternate product id
// - suspend indicator low while link suspended
// - power enable low once configured, high in suspend
// - board enables pull-down option when switching power
// - power select low bus, high self powered
// - external reset low resets the device
// - reset output floats 5 ms then drives high
// - external reset forces reset output low
// - usb bus reset leaves reset output alone
// - tx led pulses low on usb transmit
// - rx led pulses low on usb receive
// - osc output stops while suspended
// - test input low for normal operation
// - reset output low during device reset; code drives it low only under external reset
// - eeprom pins float with pull-ups in reset
//
// The register offsets and the APB slave port were left to the implementer.
`timescale 1ns/10ps
`include "upr_regs.svh"
module upr_device import upr_pkg::*; #(
  parameter int POR_CYCLES = `UPR_POR_WAIT_NS / `UPR_CLK_PERIOD_NS,
  parameter int LED_CYCLES = `UPR_LED_PULSE_NS / `UPR_CLK_PERIOD_NS,
  parameter int OSC_HALF_CYCLES = `UPR_OSC_HALF_NS / `UPR_CLK_PERIOD_NS,
  parameter logic [`UPR_PID_W-1:0] PID_DEFAULT = `UPR_PID_DEFAULT,
  parameter logic [`UPR_PID_W-1:0] PID_ALT = `UPR_PID_ALT
) (
  input wire logic CLK_SYS,
  input wire logic RST,
  upr_if.dev PINS,
  input wire logic USB_CONFIGURED,
  input wire logic USB_SUSPEND,
  input wire logic USB_BUS_RESET,
  input wire logic USB_TX_PKT,
  input wire logic USB_RX_PKT,
  output logic CORE_RESET,
  output logic CLK_MODE_48M,
  output logic [`UPR_PID_W-1:0] PRODUCT_ID,
  output logic SELF_POWERED,
  output logic TEST_MODE_ACTIVE
);
  localparam int POR_W = $clog2(POR_CYCLES + 1);
  localparam int LED_W = $clog2(LED_CYCLES + 1);
  localparam int OSC_W = $clog2(OSC_HALF_CYCLES + 1);

  // two-stage synchroniser; only s2 is read by logic
  logic [`UPR_SYN_W-1:0] syn1_q, syn2_q;
  wire [`UPR_SYN_W-1:0] pin_raw = {PINS.ee_data_lvl, PINS.ee_sk_lvl, PINS.ee_cs_lvl,
                                   PINS.test_mode, PINS.power_source_select,
                                   PINS.reset_in_n};
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      syn1_q <= `UPR_SYN_INIT;
      syn2_q <= `UPR_SYN_INIT;
    end else begin
      syn1_q <= pin_raw;
      syn2_q <= syn1_q;
    end
  end

  wire ext_rst = ~syn2_q[`UPR_SYN_RSTN];
  wire self_pwr_s = syn2_q[`UPR_SYN_PWRSEL];
  wire test_s = syn2_q[`UPR_SYN_TEST];
  wire cs_s = syn2_q[`UPR_SYN_CS];
  wire sk_s = syn2_q[`UPR_SYN_SK];

  // power-on wait, counted only while the external reset is released
  logic [POR_W-1:0] por_cnt_q, por_cnt_d;
  logic por_done_q, por_done_d;
  wire por_last = (por_cnt_q == POR_W'(POR_CYCLES - 1));
  assign por_done_d = por_done_q | (~ext_rst & por_last);
  assign por_cnt_d = (por_done_q | ext_rst) ? por_cnt_q : por_cnt_q + POR_W'(1);
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      por_cnt_q <= '0;
      por_done_q <= 1'b0;
    end else begin
      por_cnt_q <= por_cnt_d;
      por_done_q <= por_done_d;
    end
  end

  // usb bus reset deliberately has no path into core reset or the reset output
  wire core_rst = RST | ext_rst | ~por_done_q;

  upr_rst_state_t rs_q, rs_d;
  always_comb begin
    rs_d = rs_q;
    unique case (rs_q)
      UPR_RS_HIZ: begin
        if (ext_rst) rs_d = UPR_RS_LOW;
        else if (por_done_d) rs_d = UPR_RS_HIGH;
      end
      UPR_RS_LOW: begin
        if (!ext_rst) rs_d = por_done_q ? UPR_RS_HIGH : UPR_RS_HIZ;
      end
      UPR_RS_HIGH: begin
        if (ext_rst) rs_d = UPR_RS_LOW;
      end
      default: rs_d = UPR_RS_HIZ;
    endcase
  end
  always_ff @(posedge CLK_SYS) begin
    if (RST) rs_q <= UPR_RS_HIZ;
    else rs_q <= rs_d;
  end
  // low whenever it drives in reset, floating only through the power-on wait
  assign PINS.rst_out_oe = (rs_q != UPR_RS_HIZ);
  assign PINS.rst_out_o = (rs_q == UPR_RS_HIGH);

  // straps: tracked while the pins float, frozen at reset release
  logic cs_strap_q, sk_strap_q, core_rst_q;
  always_ff @(posedge CLK_SYS) begin
    if (RST) core_rst_q <= 1'b1;
    else core_rst_q <= core_rst;
  end
  always_ff @(posedge CLK_SYS) begin
    if (core_rst) begin
      cs_strap_q <= cs_s;
      sk_strap_q <= sk_s;
    end
  end

  // eeprom pins float during reset; pull-ups live on the pin model
  assign PINS.ee_cs_oe = ~core_rst_q;
  assign PINS.ee_sk_oe = ~core_rst_q;
  assign PINS.ee_data_oe = 1'b0;
  assign PINS.ee_cs_o = 1'b0;
  assign PINS.ee_sk_o = 1'b0;
  assign PINS.ee_data_o = 1'b0;

  logic clk48_q, self_pwr_q, test_q;
  logic [`UPR_PID_W-1:0] pid_q;
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      clk48_q <= 1'b0;
      pid_q <= PID_DEFAULT;
      self_pwr_q <= 1'b0;
      test_q <= 1'b0;
    end else begin
      clk48_q <= ~cs_strap_q;
      pid_q <= sk_strap_q ? PID_DEFAULT : PID_ALT;
      self_pwr_q <= self_pwr_s;
      test_q <= test_s;
    end
  end
  assign CLK_MODE_48M = clk48_q;
  assign PRODUCT_ID = pid_q;
  assign SELF_POWERED = self_pwr_q;
  assign TEST_MODE_ACTIVE = test_q;
  assign CORE_RESET = core_rst_q;

  // configuration and suspend
  logic cfg_q, susp_n_q, pwr_en_n_q;
  wire cfg_d = USB_CONFIGURED | (cfg_q & ~USB_BUS_RESET);
  always_ff @(posedge CLK_SYS) begin
    if (core_rst) begin
      cfg_q <= 1'b0;
      susp_n_q <= 1'b1;
      pwr_en_n_q <= 1'b1;
    end else begin
      cfg_q <= cfg_d;
      susp_n_q <= ~USB_SUSPEND;
      pwr_en_n_q <= ~(cfg_d & ~USB_SUSPEND);
    end
  end
  assign PINS.suspend_n = susp_n_q;
  assign PINS.power_enable_n = pwr_en_n_q;

  // activity leds: each event retriggers a fixed stretch so short packets stay visible
  wire [1:0] led_evt = {USB_RX_PKT, USB_TX_PKT};
  logic [1:0] led_on;
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_led
      logic [LED_W-1:0] cnt_q;
      always_ff @(posedge CLK_SYS) begin
        if (core_rst) cnt_q <= '0;
        else if (led_evt[g]) cnt_q <= LED_W'(LED_CYCLES);
        else if (cnt_q != '0) cnt_q <= cnt_q - LED_W'(1);
      end
      assign led_on[g] = (cnt_q != '0);
    end
  endgenerate
  assign PINS.tx_led_oe = led_on[0];
  assign PINS.rx_led_oe = led_on[1];
  assign PINS.tx_led_o = 1'b0;
  assign PINS.rx_led_o = 1'b0;

  // oscillator output approximated by a divider; frozen level during suspend
  logic [OSC_W-1:0] osc_cnt_q;
  logic osc_q;
  wire osc_wrap = (osc_cnt_q == OSC_W'(OSC_HALF_CYCLES - 1));
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      osc_cnt_q <= '0;
      osc_q <= 1'b0;
    end else if (!USB_SUSPEND) begin
      osc_cnt_q <= osc_wrap ? '0 : osc_cnt_q + OSC_W'(1);
      osc_q <= osc_q ^ osc_wrap;
    end
  end
  assign PINS.osc_out = osc_q;
endmodule : upr_device

// ### rtl/upr_board.sv
// board end: external reset, power select, test strap and pull-downs set over APB
// assumes a zero-wait APB master on CLK_SYS; device pins sampled through two flops
`timescale 1ns/10ps
`include "upr_regs.svh"
module upr_board import upr_pkg::*; (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [`UPR_ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  upr_if.brd PINS
);
  logic [`UPR_CTRL_W-1:0] ctrl_q;
  logic [`UPR_STAT_W-1:0] st1_q, st2_q;

  wire access = PSEL & PENABLE;
  wire sel_ctrl = (PADDR == `UPR_OFF_CTRL);
  wire sel_stat = (PADDR == `UPR_OFF_STATUS);
  wire wr_ctrl = access & PWRITE & sel_ctrl;

  always_ff @(posedge CLK_SYS) begin
    if (RST) ctrl_q <= `UPR_CTRL_RESET;
    else if (wr_ctrl) ctrl_q <= PWDATA[`UPR_CTRL_W-1:0];
  end

  // the board must keep the test input low unless factory test is wanted
  assign PINS.reset_in_n = ~ctrl_q[`UPR_CTRL_EXT_RST];
  assign PINS.power_source_select = ctrl_q[`UPR_CTRL_SELF_PWR];
  assign PINS.test_mode = ctrl_q[`UPR_CTRL_TEST];
  assign PINS.cs_pulldown = ctrl_q[`UPR_CTRL_CS_PD];
  assign PINS.sk_pulldown = ctrl_q[`UPR_CTRL_SK_PD];

  wire [`UPR_STAT_W-1:0] st_raw = {PINS.osc_out, PINS.ee_data_oe, PINS.ee_sk_oe,
                                   PINS.ee_cs_oe, PINS.rx_led_oe, PINS.tx_led_oe,
                                   PINS.power_enable_n, PINS.suspend_n,
                                   PINS.rst_out_oe, PINS.rst_out_o, 1'b0};
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      st1_q <= '0;
      st2_q <= '0;
    end else begin
      st1_q <= st_raw;
      st2_q <= st1_q;
    end
  end

  wire [31:0] rd_ctrl = {{(32 - `UPR_CTRL_W){1'b0}}, ctrl_q};
  wire [31:0] rd_stat = {{(32 - `UPR_STAT_W){1'b0}}, st2_q};
  wire [31:0] rd_mux = sel_ctrl ? rd_ctrl : (sel_stat ? rd_stat : 32'h0000_0000);
  wire setup_ph = PSEL & ~PENABLE;
  // read word captured in setup so the zero-wait access phase returns a flop
  logic [31:0] prdata_q;
  always_ff @(posedge CLK_SYS) begin
    if (RST) prdata_q <= 32'h0000_0000;
    else if (setup_ph) prdata_q <= rd_mux;
  end
  assign PRDATA = prdata_q;
  assign PREADY = 1'b1;
  assign PSLVERR = access & ~sel_ctrl & ~(sel_stat & ~PWRITE);
endmodule : upr_board

// ### tb/upr_pins_chk.sv
// assertions on the pin interface between the bridge end and the board end
// assumes one clock domain and a synchronous active-high reset
`timescale 1ns/10ps
module upr_pins_chk (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic ee_cs_oe,
  input wire logic ee_sk_oe,
  input wire logic ee_data_oe,
  input wire logic rst_out_o,
  input wire logic rst_out_oe,
  input wire logic tx_led_o,
  input wire logic tx_led_oe,
  input wire logic rx_led_o,
  input wire logic rx_led_oe,
  input wire logic suspend_n,
  input wire logic power_enable_n,
  input wire logic osc_out,
  input wire logic reset_in_n
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  a_float_no_eeprom: assert property (!rst_out_oe |-> !ee_cs_oe && !ee_sk_oe && !ee_data_oe)
    else $error("eeprom pins driven during power-on wait");
  a_drive_sticky: assert property (rst_out_oe |=> rst_out_oe)
    else $error("reset output floats again after power-on wait");
  a_ext_rst_low: assert property (!reset_in_n [*3] ##0 rst_out_oe
      |-> ##[0:1] (rst_out_oe && !rst_out_o))
    else $error("reset output not low under external reset");
  a_out_hold_high: assert property (reset_in_n [*3] ##0 (rst_out_oe && rst_out_o)
      |=> rst_out_o)
    else $error("reset output fell without external reset");
  a_pwr_off_susp: assert property (!suspend_n |-> power_enable_n)
    else $error("power enable active while suspended");
  a_osc_frozen: assert property (!suspend_n |-> $stable(osc_out))
    else $error("osc output toggled in suspend");
  a_osc_half_len: assert property ($changed(osc_out) |=> $stable(osc_out) [*7])
    else $error("osc output half period too short");
  // led counts run with the bench's short pulse length of 8
  a_tx_led_len: assert property ($rose(tx_led_oe) |-> tx_led_oe [*8])
    else $error("tx led pulse too short");
  a_rx_led_len: assert property ($rose(rx_led_oe) |-> rx_led_oe [*8])
    else $error("rx led pulse too short");
  a_led_open_drain: assert property (!tx_led_o && !rx_led_o)
    else $error("led pin driven high");
endmodule : upr_pins_chk

// ### tb/usb_uart_power_reset_pins_test.sv
// self-checking bench: bridge pin logic facing the board end across the pin interface
// assumes short power-on and led counts handed to the bridge as parameters
`timescale 1ns/10ps
`include "upr_regs.svh"
module usb_uart_power_reset_pins_test;
  localparam int POR = 50;
  localparam int LED = 8;
  logic CLK_SYS, RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
  logic [`UPR_ADDR_W-1:0] PADDR;
  logic [31:0] PWDATA, PRDATA;
  logic cfg, susp, bus_rst, tx_pkt, rx_pkt, core_rst, mode48, self_pwr, test_act;
  logic [`UPR_PID_W-1:0] pid;
  int fails = 0;
  int samples_checked = 0;

  upr_if pins ();
  upr_device #(.POR_CYCLES(POR), .LED_CYCLES(LED)) u_upr_device (.CLK_SYS(CLK_SYS), .RST(RST),
    .PINS(pins), .USB_CONFIGURED(cfg), .USB_SUSPEND(susp), .USB_BUS_RESET(bus_rst),
    .USB_TX_PKT(tx_pkt), .USB_RX_PKT(rx_pkt), .CORE_RESET(core_rst), .CLK_MODE_48M(mode48),
    .PRODUCT_ID(pid), .SELF_POWERED(self_pwr), .TEST_MODE_ACTIVE(test_act));
  upr_board u_upr_board (.CLK_SYS(CLK_SYS), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .PINS(pins));
  upr_pins_chk u_upr_pins_chk (.CLK_SYS(CLK_SYS), .RST(RST), .ee_cs_oe(pins.ee_cs_oe),
    .ee_sk_oe(pins.ee_sk_oe), .ee_data_oe(pins.ee_data_oe), .rst_out_o(pins.rst_out_o),
    .rst_out_oe(pins.rst_out_oe), .tx_led_o(pins.tx_led_o), .tx_led_oe(pins.tx_led_oe),
    .rx_led_o(pins.rx_led_o), .rx_led_oe(pins.rx_led_oe), .suspend_n(pins.suspend_n),
    .power_enable_n(pins.power_enable_n), .osc_out(pins.osc_out),
    .reset_in_n(pins.reset_in_n));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge CLK_SYS);
    #1;
  endtask : tick

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    int n;
    @(posedge CLK_SYS);
    PSEL <= 1'b1;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK_SYS);
    PENABLE <= 1'b1;
    n = 0;
    do begin
      @(posedge CLK_SYS);
      n++;
    end while (PREADY !== 1'b1 && n < 50);
    if (PREADY !== 1'b1) fails++;
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask : apb

  task automatic wr_ctrl(input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, `UPR_OFF_CTRL, d, r, e);
  endtask : wr_ctrl

  task automatic wait_run();
    int n;
    n = 0;
    while (core_rst !== 1'b0 && n < 300) begin
      tick(1);
      n++;
    end
    chk(core_rst, 1'b0);
  endtask : wait_run

  task automatic t_power_on();
    int n;
    n = 0;
    chk({pins.rst_out_oe, pins.ee_cs_oe, pins.ee_sk_oe, pins.ee_data_oe}, 4'h0);
    chk({pins.ee_cs_lvl, pins.ee_sk_lvl, pins.ee_data_lvl, core_rst}, 4'hf);
    // external logic stays unpowered until the host configures the bridge
    chk({pins.suspend_n, pins.power_enable_n}, 2'b11);
    while (pins.rst_out_oe !== 1'b1 && n < 200) begin
      tick(1);
      n++;
    end
    chk(n >= POR && n <= POR + 8, 1'b1);
    chk(pins.rst_out_o, 1'b1);
    wait_run();
    tick(2);
    chk({pins.ee_cs_oe, pins.ee_sk_oe, pins.ee_data_oe}, 3'b110);
    $display("test power_on done");
  endtask : t_power_on

  // every strap pair, latched through an external reset
  task automatic t_straps();
    logic [31:0] r;
    logic e;
    for (int i = 0; i < 4; i++) begin
      wr_ctrl(32'h1 | (i << 3));
      tick(6);
      chk({pins.rst_out_oe, pins.rst_out_o, core_rst}, 3'b101);
      apb(1'b0, `UPR_OFF_STATUS, 32'h0, r, e);
      chk(r[2:1], 2'b10);
      wr_ctrl(i << 3);
      wait_run();
      chk(pins.rst_out_o, 1'b1);
      chk({mode48, pid}, {i[0], i[1] ? `UPR_PID_ALT : `UPR_PID_DEFAULT});
      wr_ctrl((3 - i) << 3);
      tick(6);
      chk({mode48, pid}, {i[0], i[1] ? `UPR_PID_ALT : `UPR_PID_DEFAULT});
    end
    apb(1'b0, 12'h008, 32'h0, r, e);
    chk(e, 1'b1);
    chk(r, 32'h0000_0000);
    $display("test straps done");
  endtask : t_straps

  task automatic t_power_bits();
    for (int b = 1; b < 3; b++) begin
      wr_ctrl(32'h1 << b);
      tick(6);
      chk({self_pwr, test_act}, (b == 1) ? 2'b10 : 2'b01);
    end
    wr_ctrl(32'h0);
    tick(6);
    chk({self_pwr, test_act}, 2'b00);
    $display("test power_bits done");
  endtask : t_power_bits

  task automatic t_led(input logic rx);
    @(posedge CLK_SYS);
    tx_pkt <= ~rx;
    rx_pkt <= rx;
    @(posedge CLK_SYS);
    tx_pkt <= 1'b0;
    rx_pkt <= 1'b0;
    #1;
    chk({pins.tx_led_oe, pins.rx_led_oe}, {~rx, rx});
    tick(LED - 1);
    chk({pins.tx_led_oe, pins.rx_led_oe}, {~rx, rx});
    tick(1);
    chk({pins.tx_led_oe, pins.rx_led_oe}, 2'b00);
  endtask : t_led

  task automatic t_usb();
    logic o;
    int n;
    @(posedge CLK_SYS);
    cfg <= 1'b1;
    @(posedge CLK_SYS);
    cfg <= 1'b0;
    #1;
    chk(pins.power_enable_n, 1'b0);
    t_led(1'b0);
    t_led(1'b1);
    n = 0;
    repeat (40) begin
      o = pins.osc_out;
      tick(1);
      n += (pins.osc_out !== o);
    end
    chk(n, 32'd5);
    @(posedge CLK_SYS);
    susp <= 1'b1;
    tick(2);
    chk({pins.suspend_n, pins.power_enable_n}, 2'b01);
    o = pins.osc_out;
    tick(30);
    chk(pins.osc_out, o);
    @(posedge CLK_SYS);
    susp <= 1'b0;
    tick(2);
    chk({pins.suspend_n, pins.power_enable_n}, 2'b10);
    @(posedge CLK_SYS);
    bus_rst <= 1'b1;
    @(posedge CLK_SYS);
    bus_rst <= 1'b0;
    tick(10);
    chk({pins.rst_out_oe, pins.rst_out_o, core_rst}, 3'b110);
    $display("test usb done");
  endtask : t_usb

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : wrap_up

  initial begin
    CLK_SYS = 1'b0;
    forever #5 CLK_SYS = ~CLK_SYS;
  end

  initial begin
    {RST, PSEL, PENABLE, PWRITE, PADDR, PWDATA} = {4'h8, 44'h0};
    {cfg, susp, bus_rst, tx_pkt, rx_pkt} = 5'h0;
    repeat (5) @(posedge CLK_SYS);
    RST <= 1'b0;
    t_power_on();
    t_straps();
    t_power_bits();
    t_usb();
    wrap_up();
  end

  // whole run is a few hundred cycles
  initial begin
    #100000;
    fails++;
    wrap_up();
  end
endmodule : usb_uart_power_reset_pins_test
